// ===== verilog/tcw_pkg.sv
/*
  tcw_pkg: shared constants and types for the timer-counter waveform unit.
  Assumes a byte-addressed register port with 32-bit data words.
*/
`default_nettype none
package tcw_pkg;
  // register byte offsets
  localparam logic [7:0] TCW_OFS_CTRLA = 8'h00; // enable, size, wave mode, one-shot
  localparam logic [7:0] TCW_OFS_CONTROL_B_REGISTER_SET = 8'h04; // read: direction; write: set dir, command
  localparam logic [7:0] TCW_OFS_CONTROL_B_REGISTER_CLR = 8'h08; // write one clears direction
  localparam logic [7:0] TCW_OFS_TRIG_CTRL = 8'h0C; // input action, wrap event enable
  localparam logic [7:0] TCW_OFS_IRQ_FLAG = 8'h10; // sticky flags, write one to clear
  localparam logic [7:0] TCW_OFS_IRQ_MASK = 8'h14; // same layout as flags
  localparam logic [7:0] TCW_OFS_STATUS = 8'h18; // stop, follower, running
  localparam logic [7:0] TCW_OFS_COUNT = 8'h1C;
  localparam logic [7:0] TCW_OFS_CYCLE = 8'h20; // cycle length value, 8-bit mode
  localparam logic [7:0] TCW_OFS_CMP0 = 8'h24; // first compare value
  localparam logic [7:0] TCW_OFS_CMP1 = 8'h28;
  // field positions
  localparam int TCW_B_DIR = 0; // direction bit in control b
  localparam int TCW_B_CMD = 6; // command field low bit in control b set
  localparam int TCW_B_WRAP_OE = 8; // wrap trigger output enable in trigger control
  localparam int TCW_B_FLG_WRAP = 0; // wrap flag
  localparam int TCW_B_FLG_MC = 4; // match/capture flags start here
  localparam int TCW_B_ST_STOP = 0;
  localparam int TCW_B_ST_FOLLOW = 1;
  localparam int TCW_B_ST_RUN = 2;
  // commands and input actions
  localparam logic [1:0] TCW_CMD_RESTART = 2'h1;
  localparam logic [1:0] TCW_CMD_STOP = 2'h2;
  localparam logic [1:0] TCW_ACT_RESTART = 2'h1;
  localparam logic [1:0] TCW_ACT_COUNT = 2'h2;
  // reset values and full-scale limits
  localparam logic [31:0] TCW_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] TCW_RST_CYCLE = 32'h0000_00FF;
  localparam logic [31:0] TCW_MAX16 = 32'h0000_FFFF;
  localparam logic [31:0] TCW_MAX32 = 32'hFFFF_FFFF;
  // counter size and waveform encodings
  typedef enum logic [1:0] {TCW_SZ16 = 2'h0, TCW_SZ8 = 2'h1, TCW_SZ32 = 2'h2, TCW_SZRSV = 2'h3} tcw_size_t;
  typedef enum logic [1:0] {TCW_WV_MATCH = 2'h0, TCW_WV_FIRST = 2'h1, TCW_WV_SLOPE = 2'h2, TCW_WV_RSV = 2'h3} tcw_wave_t;
  // control a layout
  typedef struct packed {
    logic [24:0] rsv;
    logic one_shot;
    tcw_wave_t wave;
    tcw_size_t size;
    logic enable;
  } tcw_ctrla_t;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tcw_req_t;
endpackage
`default_nettype wire

// ===== verilog/tcw_unit.sv
/*
  tcw_unit: one timer-counter unit with up/down counting, one-shot, stop and
  restart commands, three waveform modes, wrap event, interrupt and pairing.
  Assumes a same-clock register master, and a partner unit on the same clock.
*/
// Local design decisions: the address-and-strobe port and the register addresses.
// What this block does
// - up count wraps to zero after top
// - down count reloads top at zero
// - one-shot halts after first wraparound
// - direction bit: clear up, set down
// - one step per tick, clock or event
// - upward wrap sets wrap flag
// - wrap event only when output enabled
// - count write beats count, clear, reload
// - start from zero or top by direction
// - stop loads start, clears waves, sets stop
// - restart from software or input event
// - match mode period: cycle length or max
// - match toggles output, sets match flag
// - first compare sets period, toggles out0
// - up slope: high at top, low at compare
// - down slope: low at zero, high compare
// - even unit configures pair, odd follows
// - follower count, compares read zero; writes dropped
`timescale 1ns/1ps
`default_nettype none
module tcw_unit
  import tcw_pkg::*;
#(
  parameter bit ODD_UNIT = 1'b0 // odd-numbered unit of a pair
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // events and pairing
  input wire logic i_evt,
  input wire logic i_pair_32,
  output logic o_pair_32,
  output logic o_wrap_evt,
  // waveform and interrupt
  output logic [1:0] o_wave,
  output logic o_irq
);

  // returns the full-scale limit for the selected size
  function automatic logic [31:0] size_max(input tcw_size_t sz, input logic [31:0] cyc);
    case (sz)
      TCW_SZ8: size_max = {24'h00_0000, cyc[7:0]};
      TCW_SZ32: size_max = TCW_MAX32;
      default: size_max = TCW_MAX16;
    endcase
  endfunction

  tcw_req_t req; // bundled register request
  tcw_ctrla_t ctrla_r; // configuration
  logic dir_r; // 1 = count down
  logic [1:0] act_r; // input trigger action
  logic wrap_oe_r; // wrap trigger output enable
  logic [31:0] count_r;
  logic [31:0] cycle_r;
  logic [31:0] cmp_r [2]; // compare values
  logic [5:0] flag_r; // irq flag register
  logic [5:0] mask_r;
  logic stop_r; // stop status
  logic run_r; // counter running
  logic follow_r; // follower status
  logic cnt_wr_r; // software wrote count since last start
  logic [31:0] max_c; // full-scale limit
  logic [31:0] top_c; // active top value
  logic [31:0] start_c; // direction-dependent start value
  logic follower; // this unit is a follower
  logic cnt_wr, stop_cmd, restart, start_en, tick, wrap, wrap_up;
  logic [1:0] match;
  logic [5:0] flag_set, flag_clr;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // period source per wave mode and size
  always_comb begin
    max_c = size_max(ctrla_r.size, cycle_r);
    top_c = (ctrla_r.wave == TCW_WV_FIRST) ? (cmp_r[0] & max_c) : max_c;
    start_c = dir_r ? top_c : TCW_RST_ZERO;
  end

  // command and tick decode; follower ignores counter writes and never runs
  assign follower = ODD_UNIT && i_pair_32;
  assign cnt_wr = req.wr && req.addr == TCW_OFS_COUNT && !follower;
  assign stop_cmd = req.wr && req.addr == TCW_OFS_CONTROL_B_REGISTER_SET && run_r && !follower
    && req.wdata[TCW_B_CMD +: 2] == TCW_CMD_STOP;
  assign restart = !follower && ((req.wr && req.addr == TCW_OFS_CONTROL_B_REGISTER_SET
    && req.wdata[TCW_B_CMD +: 2] == TCW_CMD_RESTART) || (i_evt && act_r == TCW_ACT_RESTART));
  assign start_en = req.wr && req.addr == TCW_OFS_CTRLA && req.wdata[0] && !run_r && !follower;
  assign tick = run_r && !follower && (act_r == TCW_ACT_COUNT ? i_evt : 1'b1);
  assign wrap = tick && (dir_r ? count_r == TCW_RST_ZERO : count_r == top_c) && !cnt_wr && !stop_cmd && !restart;
  assign wrap_up = wrap && !dir_r;
  assign match[0] = tick && count_r == (cmp_r[0] & max_c);
  assign match[1] = tick && count_r == (cmp_r[1] & max_c);

  // counter value: software write first, then stop, restart, start, counting
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      count_r <= TCW_RST_ZERO;
    end else if (cnt_wr) begin
      count_r <= req.wdata & max_c;
    end else if (stop_cmd || restart) begin
      count_r <= start_c;
    end else if (start_en && !cnt_wr_r && count_r == TCW_RST_ZERO) begin
      count_r <= start_c;
    end else if (wrap) begin
      count_r <= dir_r ? top_c : TCW_RST_ZERO;
    end else if (tick) begin
      count_r <= dir_r ? count_r - 32'h0000_0001 : count_r + 32'h0000_0001;
    end
  end

  // remembers a software count write so a start keeps that value
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_wr_r <= 1'b0;
    end else if (cnt_wr) begin
      cnt_wr_r <= 1'b1;
    end else if (start_en || restart || stop_cmd) begin
      cnt_wr_r <= 1'b0;
    end
  end

  // run state; one-shot drops it after the first wrap
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      run_r <= 1'b0;
    end else if (stop_cmd) begin
      run_r <= 1'b0;
    end else if (restart) begin
      run_r <= 1'b1;
    end else if (req.wr && req.addr == TCW_OFS_CTRLA && !follower) begin
      run_r <= req.wdata[0];
    end else if (wrap && ctrla_r.one_shot) begin
      run_r <= 1'b0;
    end
  end

  // stop status: hardware set and cleared by starting again
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_r <= 1'b1;
    end else if (stop_cmd || (wrap && ctrla_r.one_shot)) begin
      stop_r <= 1'b1;
    end else if (restart || start_en) begin
      stop_r <= 1'b0;
    end
  end

  // software-owned configuration registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrla_r <= '0;
      dir_r <= 1'b0;
      act_r <= 2'h0;
      wrap_oe_r <= 1'b0;
      cycle_r <= TCW_RST_CYCLE;
      cmp_r[0] <= TCW_RST_ZERO;
      cmp_r[1] <= TCW_RST_ZERO;
      mask_r <= 6'h00;
    end else if (req.wr && !follower) begin
      // a follower's writes are dropped so the paired counter is untouched
      unique case (req.addr)
        TCW_OFS_CTRLA: ctrla_r <= tcw_ctrla_t'({25'h000_0000, req.wdata[6:0]});
        TCW_OFS_CONTROL_B_REGISTER_SET: dir_r <= dir_r | req.wdata[TCW_B_DIR];
        TCW_OFS_CONTROL_B_REGISTER_CLR: dir_r <= dir_r & ~req.wdata[TCW_B_DIR];
        TCW_OFS_TRIG_CTRL: begin
          act_r <= req.wdata[1:0];
          wrap_oe_r <= req.wdata[TCW_B_WRAP_OE];
        end
        TCW_OFS_IRQ_MASK: mask_r <= req.wdata[5:0];
        TCW_OFS_CYCLE: cycle_r <= {24'h00_0000, req.wdata[7:0]};
        TCW_OFS_CMP0: cmp_r[0] <= req.wdata;
        TCW_OFS_CMP1: cmp_r[1] <= req.wdata;
        default: ;
      endcase
    end
  end

  // sticky flags; a set in the clearing cycle wins
  assign flag_set = {match, 3'b000, wrap_up};
  // a follower drops every write, the flag clear included
  assign flag_clr = (req.wr && req.addr == TCW_OFS_IRQ_FLAG && !follower) ? req.wdata[5:0] : 6'h00;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_r <= 6'h00;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | flag_set;
    end
  end

  // waveform generation per mode; stop clears both outputs
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wave <= 2'b00;
    end else if (stop_cmd) begin
      o_wave <= 2'b00;
    end else if (ctrla_r.wave == TCW_WV_MATCH) begin
      o_wave <= o_wave ^ match;
    end else if (ctrla_r.wave == TCW_WV_FIRST) begin
      o_wave[0] <= o_wave[0] ^ wrap;
    end else if (ctrla_r.wave == TCW_WV_SLOPE) begin
      for (int i = 0; i < 2; i++) begin
        if (restart || start_en) begin
          o_wave[i] <= !dir_r;
        end else if (match[i]) begin
          o_wave[i] <= dir_r;
        end else if (tick && !dir_r && count_r == top_c) begin
          o_wave[i] <= 1'b1;
        end else if (tick && dir_r && count_r == TCW_RST_ZERO) begin
          o_wave[i] <= 1'b0;
        end
      end
    end
  end

  // event, interrupt and pairing outputs, all registered
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wrap_evt <= 1'b0;
      o_irq <= 1'b0;
      o_pair_32 <= 1'b0;
      follow_r <= 1'b0;
    end else begin
      o_wrap_evt <= wrap && wrap_oe_r;
      o_irq <= |(flag_r & mask_r);
      o_pair_32 <= !ODD_UNIT && ctrla_r.size == TCW_SZ32;
      follow_r <= follower;
    end
  end

  // read data one cycle after the strobe; unmapped and follower counter read zero
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= TCW_RST_ZERO;
    end else if (req.rd) begin
      unique case (req.addr)
        TCW_OFS_CTRLA: o_rdata <= ctrla_r;
        TCW_OFS_CONTROL_B_REGISTER_SET: o_rdata <= {31'h0000_0000, dir_r};
        TCW_OFS_TRIG_CTRL: o_rdata <= {23'h00_0000, wrap_oe_r, 6'h00, act_r};
        TCW_OFS_IRQ_FLAG: o_rdata <= {26'h000_0000, flag_r};
        TCW_OFS_IRQ_MASK: o_rdata <= {26'h000_0000, mask_r};
        TCW_OFS_STATUS: o_rdata <= {29'h0000_0000, run_r, follow_r, stop_r};
        TCW_OFS_COUNT: o_rdata <= follower ? TCW_RST_ZERO : count_r;
        TCW_OFS_CYCLE: o_rdata <= cycle_r;
        TCW_OFS_CMP0: o_rdata <= follower ? TCW_RST_ZERO : cmp_r[0];
        TCW_OFS_CMP1: o_rdata <= follower ? TCW_RST_ZERO : cmp_r[1];
        default: o_rdata <= TCW_RST_ZERO;
      endcase
    end else begin
      o_rdata <= TCW_RST_ZERO;
    end
  end

  // checks beside the logic
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_up_wrap_zero: assert property (wrap_up |=> count_r == 32'h0000_0000)
    else $error("up wrap did not return to zero");
  a_down_reload: assert property (wrap && dir_r && !ctrla_r.one_shot |=> count_r == $past(top_c))
    else $error("down wrap did not reload top");
  a_oneshot_halt: assert property (wrap && ctrla_r.one_shot |=> !run_r ##1 $stable(count_r))
    else $error("one-shot kept counting");
  a_up_step: assert property (tick && !dir_r && !wrap && !cnt_wr && !stop_cmd && !restart
    |=> count_r == $past(count_r) + 32'h0000_0001)
    else $error("up step wrong");
  a_down_step: assert property (tick && dir_r && !wrap && !cnt_wr && !stop_cmd && !restart
    |=> count_r == $past(count_r) - 32'h0000_0001)
    else $error("down step wrong");
  a_wrap_flag: assert property (wrap_up |=> flag_r[TCW_B_FLG_WRAP])
    else $error("wrap flag not set");
  a_wrap_event: assert property (o_wrap_evt |-> $past(wrap) && $past(wrap_oe_r))
    else $error("wrap event without cause");
  a_count_write: assert property (cnt_wr |=> count_r == ($past(req.wdata) & $past(max_c)))
    else $error("count write lost");
  a_stop_clear: assert property (stop_cmd && !cnt_wr |=> o_wave == 2'b00 && stop_r && !run_r
    && count_r == $past(start_c))
    else $error("stop action incomplete");
  a_restart_run: assert property (restart && !stop_cmd && !cnt_wr |=> run_r && count_r == $past(start_c))
    else $error("restart did not reload and run");
  a_match_toggle: assert property (ctrla_r.wave == TCW_WV_MATCH && match[0] && !stop_cmd
    |=> o_wave[0] != $past(o_wave[0]) && flag_r[TCW_B_FLG_MC])
    else $error("match did not toggle");
  a_follow_still: assert property (follower && $past(follower) |-> $stable(count_r))
    else $error("follower counter moved");
  a_slope_low: assert property (ctrla_r.wave == TCW_WV_SLOPE && match[0] && !dir_r && !stop_cmd && !restart
    && !start_en |=> !o_wave[0])
    else $error("slope output not cleared at compare");

  c_up_wrap: cover property (wrap_up ##1 o_wrap_evt);
  c_oneshot: cover property (ctrla_r.one_shot && wrap);
  c_stop: cover property (run_r ##1 stop_cmd);
  c_slope: cover property (ctrla_r.wave == TCW_WV_SLOPE && match[1]);

endmodule
`default_nettype wire

// ===== sim/tcw_unit_bench.sv
/*
  tcw_unit_bench: self-checking bench for the timer-counter waveform unit.
  Assumes the register map and latencies of tcw_pkg; an even and an odd unit are paired.
*/
`timescale 1ns/1ps
`default_nettype none
module tcw_unit_bench
  import tcw_pkg::*;
;
  logic i_clk_sys; // 40 MHz system clock
  logic i_resetn; // active-low reset
  logic [7:0] addr; // shared register address
  logic [31:0] wdata; // shared write data
  logic wr, rd, odd_sel; // strobes and unit select
  logic evt; // incoming event pulse
  logic [31:0] rdata_e, rdata_o; // read data of each unit
  logic pair_e, pair_o, wrap_e, wrap_o, irq_e, irq_o; // unit outputs
  logic [1:0] wave_e, wave_o; // waveform outputs
  int errors, compares; // mismatch and comparison counters
  int n_wrap, n_high, n_tog; // figures gathered while sampling
  // even unit holds the configuration of a pair
  tcw_unit #(.ODD_UNIT(1'b0)) dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr & ~odd_sel), .i_rd(rd & ~odd_sel), .o_rdata(rdata_e), .i_evt(evt),
    .i_pair_32(1'b0), .o_pair_32(pair_e), .o_wrap_evt(wrap_e), .o_wave(wave_e), .o_irq(irq_e));
  // odd unit follows the even one when paired
  tcw_unit #(.ODD_UNIT(1'b1)) dut_odd (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr & odd_sel), .i_rd(rd & odd_sel), .o_rdata(rdata_o), .i_evt(evt),
    .i_pair_32(pair_e), .o_pair_32(pair_o), .o_wrap_evt(wrap_o), .o_wave(wave_o), .o_irq(irq_o));
  // free-running clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // one compare task for register values and outputs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one compare task for counted figures
  task automatic chk_n(input int got, input int exp, input string what);
    compares++;
    if (got != exp) begin
      errors++;
      $display("ERROR t=%0t %s count %0d exp %0d", $time, what, got, exp);
    end
  endtask
  // single-cycle write strobe, released on the next edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask
  // read strobe, data sampled in the following cycle only
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1;
    chk(odd_sel ? rdata_o : rdata_e, exp, "read");
  endtask
  // watch the even unit for n cycles: wrap pulses, wave0 high cycles, wave0 edges
  task automatic sample(input int n);
    logic last;
    n_wrap = 0;
    n_high = 0;
    n_tog = 0;
    @(posedge i_clk_sys);
    #1;
    last = wave_e[0];
    repeat (n) begin
      @(posedge i_clk_sys);
      #1;
      n_wrap += (wrap_e === 1'b1);
      n_high += (wave_e[0] === 1'b1);
      n_tog += (wave_e[0] !== last);
      last = wave_e[0];
    end
  endtask
  // single verdict point
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    int k;
    i_resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    odd_sel = 1'b0;
    evt = 1'b0;
    errors = 0;
    compares = 0;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    // reset values and an unmapped address
    reg_rd(TCW_OFS_STATUS, 32'h0000_0001);
    reg_rd(TCW_OFS_CYCLE, TCW_RST_CYCLE);
    reg_rd(8'h3C, 32'h0000_0000);
    $display("test reset done");
    // 8-bit match toggle, top 3, compare 1, wrap event and irq enabled
    reg_wr(TCW_OFS_CYCLE, 32'h0000_0003);
    reg_wr(TCW_OFS_CMP0, 32'h0000_0001);
    reg_wr(TCW_OFS_TRIG_CTRL, 32'h0000_0100);
    reg_wr(TCW_OFS_IRQ_MASK, 32'h0000_0001);
    reg_wr(TCW_OFS_CTRLA, 32'h0000_0003);
    sample(32);
    chk_n(n_wrap, 8, "wrap events");
    chk_n(n_tog, 8, "match toggles");
    reg_rd(TCW_OFS_IRQ_FLAG, 32'h0000_0031);
    chk({31'h0000_0000, irq_e}, 32'h0000_0001, "irq");
    $display("test match mode done");
    // single slope up: high from top until compare
    reg_wr(TCW_OFS_CTRLA, 32'h0000_0013);
    sample(32);
    chk_n(n_high, 16, "slope high cycles");
    reg_wr(TCW_OFS_CONTROL_B_REGISTER_SET, 32'h0000_0080);
    reg_rd(TCW_OFS_STATUS, 32'h0000_0001);
    reg_rd(TCW_OFS_COUNT, 32'h0000_0000);
    chk({30'h0000_0000, wave_e}, 32'h0000_0000, "waves after stop");
    reg_wr(TCW_OFS_IRQ_FLAG, 32'h0000_0031);
    reg_rd(TCW_OFS_IRQ_FLAG, 32'h0000_0000);
    chk({31'h0000_0000, irq_e}, 32'h0000_0000, "irq cleared");
    $display("test slope and stop done");
    // one-shot down count from top, restarted by command
    reg_wr(TCW_OFS_CONTROL_B_REGISTER_SET, 32'h0000_0001);
    reg_rd(TCW_OFS_CONTROL_B_REGISTER_SET, 32'h0000_0001);
    reg_wr(TCW_OFS_CTRLA, 32'h0000_0023);
    reg_wr(TCW_OFS_CONTROL_B_REGISTER_SET, 32'h0000_0041);
    sample(20);
    chk_n(n_wrap, 1, "one-shot wraps");
    reg_rd(TCW_OFS_STATUS, 32'h0000_0001);
    reg_rd(TCW_OFS_COUNT, 32'h0000_0003);
    reg_rd(TCW_OFS_IRQ_FLAG, 32'h0000_0030);
    $display("test one-shot down done");
    // count on events with the wrap event disabled, then a count write
    reg_wr(TCW_OFS_CONTROL_B_REGISTER_CLR, 32'h0000_0001);
    reg_wr(TCW_OFS_CTRLA, 32'h0000_0003);
    reg_wr(TCW_OFS_TRIG_CTRL, 32'h0000_0002);
    reg_wr(TCW_OFS_CONTROL_B_REGISTER_SET, 32'h0000_0040);
    reg_rd(TCW_OFS_STATUS, 32'h0000_0004);
    n_wrap = 0;
    for (k = 0; k < 10; k++) begin
      @(posedge i_clk_sys);
      evt <= (k % 2 == 0);
      #1;
      n_wrap += (wrap_e === 1'b1);
    end
    @(posedge i_clk_sys);
    evt <= 1'b0;
    reg_rd(TCW_OFS_COUNT, 32'h0000_0001);
    chk_n(n_wrap, 0, "wrap events disabled");
    reg_wr(TCW_OFS_COUNT, 32'h0000_0002);
    reg_rd(TCW_OFS_COUNT, 32'h0000_0002);
    $display("test event count done");
    // halt, then restart from an incoming event with the restart action
    reg_wr(TCW_OFS_CTRLA, 32'h0000_0002);
    reg_wr(TCW_OFS_TRIG_CTRL, 32'h0000_0001);
    reg_rd(TCW_OFS_STATUS, 32'h0000_0000);
    @(posedge i_clk_sys);
    evt <= 1'b1;
    @(posedge i_clk_sys);
    evt <= 1'b0;
    reg_rd(TCW_OFS_STATUS, 32'h0000_0004);
    $display("test event restart done");
    // 32-bit pairing: odd unit becomes follower and ignores writes
    reg_wr(TCW_OFS_CTRLA, 32'h0000_0004);
    @(posedge i_clk_sys);
    #1;
    chk({31'h0000_0000, pair_e}, 32'h0000_0001, "pair mode");
    odd_sel <= 1'b1;
    reg_rd(TCW_OFS_STATUS, 32'h0000_0003);
    reg_wr(TCW_OFS_COUNT, 32'h0000_0005);
    reg_rd(TCW_OFS_COUNT, 32'h0000_0000);
    $display("test pairing done");
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    $display("ERROR t=%0t run limit reached", $time);
    close_out();
  end
endmodule
`default_nettype wire
